/* hw/frcu_pkg.sv */
// Shared constants and types of the flash register command unit
package frcu_pkg;
    // ****************************************
    // Opcodes
    // ****************************************
    localparam logic [7:0] OP_WREN   = 8'h06;
    localparam logic [7:0] OP_WRDI   = 8'h04;
    localparam logic [7:0] OP_RDSR   = 8'h05;
    localparam logic [7:0] OP_WRSR   = 8'h01;
    localparam logic [7:0] OP_RDLOCK = 8'he8;
    localparam logic [7:0] OP_WRLOCK = 8'he5;
    localparam logic [7:0] OP_RDFSR  = 8'h70;
    localparam logic [7:0] OP_CLFSR  = 8'h50;
    localparam logic [7:0] OP_RDNVCR = 8'hb5;
    localparam logic [7:0] OP_WRNVCR = 8'hb1;
    localparam logic [7:0] OP_RDVCR  = 8'h85;
    localparam logic [7:0] OP_WRVCR  = 8'h81;
    localparam logic [7:0] OP_RDEVCR = 8'h65;
    localparam logic [7:0] OP_WREVCR = 8'h61;
    // ****************************************
    // Frame lengths in bits, offsets, resets
    // ****************************************
    localparam logic [7:0]  BITS_OP   = 8'h08;
    localparam logic [7:0]  BITS_REG  = 8'h10;
    localparam logic [7:0]  BITS_NVCR = 8'h18;
    localparam logic [7:0]  BITS_ADDR = 8'h20;
    localparam logic [7:0]  BITS_LOCK = 8'h28;
    localparam int          SECT_LSB  = 16;
    localparam logic [5:0]  STAT_RST  = 6'h00;
    localparam logic [15:0] NVCR_RST  = 16'hffff;
    localparam logic [7:0]  VCR_RST   = 8'hff;
    localparam logic [7:0]  EVCR_RST  = 8'hff;
    localparam logic [15:0] NVCR_RSVD = 16'h0010;
    localparam logic [7:0]  VCR_RSVD  = 8'h04;
    localparam logic [7:0]  EVCR_RSVD = 8'h10;
    localparam int          FSR_READY = 7;
    localparam int          FSR_ERASE = 5;
    localparam int          FSR_PROG  = 4;
    localparam int          FSR_PROT  = 1;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS           = 8;
    localparam int STATUS_WRITE_TIME_US    = 8;
    localparam int NV_CONFIG_WRITE_TIME_US = 200;
    localparam int STATUS_WRITE_CYC =
        (STATUS_WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NV_WRITE_CYC =
        (NV_CONFIG_WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {PR_EXT = 2'h0, PR_DUAL = 2'h1, PR_QUAD = 2'h2} frcu_proto_e;
    typedef enum logic [1:0] {W_IDLE = 2'h0, W_STAT = 2'h1, W_NVCR = 2'h2} frcu_wst_e;
    typedef struct packed {
        logic [7:0]  status;
        logic [7:0]  flags;
        logic [7:0]  vcr;
        logic [7:0]  evcr;
        logic [15:0] nvcr;
        logic        busy;
        frcu_proto_e proto;
    } frcu_view_s;
    typedef struct packed {
        logic [7:0]  op;
        logic [7:0]  bits;
        logic        over;
        logic [39:0] shf;
    } frcu_cap_s;
endpackage

/* hw/frcu_reg_cmd.sv */
// Serial flash register commands: link logic on the serial clock, registers on i_clk
`timescale 1ns/1ps
// Behaviour
// - NVCR read: 16 bits, then zeros
// - NVCR reserved fields read as ones
// - VCR, EVCR, lock reads repeat byte
// - Chip select high ends read immediately
// - Lanes follow extended, dual or quad
// - Status or NVCR write runs self-timed
// - Status write changes only bits 7:2
// - Busy bit during write; clears enable
// - Wrong length: discard, keep enable set
// - VCR and EVCR writes keep reserved bits; NVCR write stores them as sent
// - Lock read: three address bytes first
// - Lock read rejected while busy
// - Lock-down bit sticks until power cycle
// - Write lock blocks program and erase
// - Locked-down sector ignores lock write
// - Lock write immediate, clears enable
// - Lock write allowed during erase suspend
// - Flag clear resets error bits
// - NVCR read sends low byte first
// - No dummy on registers; address only on lock commands
module frcu_reg_cmd #(
    parameter int N_SECT           = 128,
    parameter int STATUS_WRITE_CYC = frcu_pkg::STATUS_WRITE_CYC,
    parameter int NV_WRITE_CYC     = frcu_pkg::NV_WRITE_CYC
) (
    // System clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_rst,
    // Serial link
    input  wire logic                      i_sclk,
    input  wire logic                      i_cs_n,
    input  wire logic [3:0]                i_dq,
    output logic      [3:0]                o_dq,
    output logic      [3:0]                o_dq_oe_n,
    // Device side
    input  wire frcu_pkg::frcu_proto_e     i_proto,
    input  wire logic                      i_pe_busy,
    input  wire logic                      i_erase_susp,
    input  wire logic [2:0]                i_err_set,
    input  wire logic [$clog2(N_SECT)-1:0] i_pe_sector,
    output logic                           o_pe_block,
    output logic      [7:0]                o_status,
    output logic      [7:0]                o_flags,
    output logic      [15:0]               o_nvcr,
    output logic      [7:0]                o_vcr,
    output logic      [7:0]                o_evcr
);
    localparam int SB = $clog2(N_SECT);

    frcu_pkg::frcu_view_s view, view_q, view_m, view_s;
    frcu_pkg::frcu_cap_s  cap;
    frcu_pkg::frcu_wst_e  st;
    logic [N_SECT-1:0] lkw, lkd, lkw_m, lkw_s, lkd_m, lkd_s;
    logic [7:0]  cnt, next_cnt, op, next_op, start, pos, rd_byte;
    logic [39:0] shf, next_shf;
    logic [23:0] laddr, tmr, busy_len;
    logic [3:0]  dq, drv, next_dq, next_drv;
    logic [2:0]  w, k, err;
    logic [SB-1:0] rsec, wsec;
    logic [5:0]  stat_hi;
    logic [15:0] nvcr, nv_pend;
    logic [7:0]  vcr, evcr;
    logic over, next_over, in_out, rd_en;
    logic cs_m, cs_s, cs_d, frame_end, cmd_ok, wr_gate, wel, wip, done;
    logic sr_ok, nv_ok, vcr_ok, evcr_ok, lk_ok, wren, wrdi, clr, lock_busy;

    // ****************************************
    // Link domain
    // ****************************************
    // Register view into the link domain; the opcode gives it edges to settle
    always_ff @(posedge i_sclk) begin
        view_m <= view_q;
        view_s <= view_m;
        lkw_m  <= lkw;
        lkw_s  <= lkw_m;
        lkd_m  <= lkd;
        lkd_s  <= lkd_m;
    end

    always_comb begin
        case (view_s.proto)
            frcu_pkg::PR_DUAL: begin
                w        = 3'h2;
                next_shf = {shf[37:0], i_dq[1:0]};
            end
            frcu_pkg::PR_QUAD: begin
                w        = 3'h4;
                next_shf = {shf[35:0], i_dq};
            end
            default: begin
                w        = 3'h1;
                next_shf = {shf[38:0], i_dq[0]};
            end
        endcase
        next_cnt  = cnt + {5'h00, w};
        next_over = over | (next_cnt < cnt);
        next_op   = (next_cnt == frcu_pkg::BITS_OP && !over) ? next_shf[7:0] : op;
    end

    // Frame state is cleared by chip select, as the serial clock stops between frames
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            cnt  <= 8'h00;
            over <= 1'b0;
            op   <= 8'h00;
            shf  <= 40'h0;
        end else begin
            cnt  <= next_cnt;
            over <= next_over;
            op   <= next_op;
            shf  <= next_shf;
        end
    end

    always_ff @(posedge i_sclk) begin
        if (next_cnt == frcu_pkg::BITS_ADDR && !over) begin
            laddr <= next_shf[23:0];
        end
    end

    // Held after the frame; read by i_clk only once chip select is seen high
    always_ff @(posedge i_sclk) begin
        cap <= {next_op, next_cnt, next_over, next_shf};
    end

    always_comb begin
        start   = (op == frcu_pkg::OP_RDLOCK) ? frcu_pkg::BITS_ADDR : frcu_pkg::BITS_OP;
        pos     = cnt - start;
        in_out  = over | (cnt >= start);
        rsec    = laddr[frcu_pkg::SECT_LSB +: SB];
        rd_en   = in_out;
        rd_byte = 8'h00;
        case (op)
            frcu_pkg::OP_RDSR:   rd_byte = view_s.status;
            frcu_pkg::OP_RDFSR:  rd_byte = view_s.flags;
            frcu_pkg::OP_RDVCR:  rd_byte = view_s.vcr;
            frcu_pkg::OP_RDEVCR: rd_byte = view_s.evcr;
            frcu_pkg::OP_RDNVCR: begin
                if (!over && cnt < frcu_pkg::BITS_NVCR) begin
                    rd_byte = pos[3] ? view_s.nvcr[15:8] : view_s.nvcr[7:0];
                end
            end
            frcu_pkg::OP_RDLOCK: begin
                rd_byte = {6'h00, lkd_s[rsec], lkw_s[rsec]};
                rd_en   = in_out & ~view_s.busy;
            end
            default: rd_en = 1'b0;
        endcase
    end

    // Most significant bit of each group goes on the highest lane
    always_comb begin
        next_dq  = 4'h0;
        next_drv = 4'h0;
        k        = 3'h0;
        if (rd_en && w == 3'h1) begin
            next_dq[1] = rd_byte[3'h7 - pos[2:0]];
            next_drv   = 4'h2;
        end else if (rd_en) begin
            for (int j = 0; j < 4; j++) begin
                if (3'(j) < w) begin
                    k           = 3'(pos[2:0] + w - 3'h1 - 3'(j));
                    next_dq[j]  = rd_byte[3'h7 - k];
                    next_drv[j] = 1'b1;
                end
            end
        end
    end

    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            dq  <= 4'h0;
            drv <= 4'h0;
        end else begin
            dq  <= next_dq;
            drv <= next_drv;
        end
    end

    assign o_dq      = dq;
    assign o_dq_oe_n = ~drv | {4{i_cs_n}};

    // ****************************************
    // Register domain
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            cs_d <= 1'b1;
        end else begin
            cs_m <= i_cs_n;
            cs_s <= cs_m;
            cs_d <= cs_s;
        end
    end

    assign frame_end = cs_s & ~cs_d;
    assign wip       = (st != frcu_pkg::W_IDLE);
    assign done      = wip & (tmr == 24'h0);
    assign lock_busy = wip | i_pe_busy;

    always_comb begin
        cmd_ok  = frame_end & ~cap.over & (cap.bits >= frcu_pkg::BITS_OP);
        wr_gate = cmd_ok & wel & ~wip;
        sr_ok   = wr_gate & (cap.op == frcu_pkg::OP_WRSR) & (cap.bits == frcu_pkg::BITS_REG);
        nv_ok   = wr_gate & (cap.op == frcu_pkg::OP_WRNVCR) & (cap.bits == frcu_pkg::BITS_NVCR);
        vcr_ok  = wr_gate & (cap.op == frcu_pkg::OP_WRVCR) & (cap.bits == frcu_pkg::BITS_REG);
        evcr_ok = wr_gate & (cap.op == frcu_pkg::OP_WREVCR) & (cap.bits == frcu_pkg::BITS_REG);
        lk_ok   = wr_gate & (cap.op == frcu_pkg::OP_WRLOCK) & (cap.bits == frcu_pkg::BITS_LOCK)
                  & (~i_pe_busy | i_erase_susp);
        wren    = cmd_ok & (cap.op == frcu_pkg::OP_WREN) & (cap.bits == frcu_pkg::BITS_OP);
        wrdi    = cmd_ok & (cap.op == frcu_pkg::OP_WRDI) & (cap.bits == frcu_pkg::BITS_OP);
        clr     = cmd_ok & (cap.op == frcu_pkg::OP_CLFSR);
        wsec    = cap.shf[8 + frcu_pkg::SECT_LSB +: SB];
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st  <= frcu_pkg::W_IDLE;
            tmr <= 24'h0;
        end else begin
            case (st)
                frcu_pkg::W_IDLE: begin
                    if (sr_ok) begin
                        st  <= frcu_pkg::W_STAT;
                        tmr <= 24'(STATUS_WRITE_CYC - 1);
                    end else if (nv_ok) begin
                        st  <= frcu_pkg::W_NVCR;
                        tmr <= 24'(NV_WRITE_CYC - 1);
                    end
                end
                frcu_pkg::W_STAT, frcu_pkg::W_NVCR: begin
                    if (done) begin
                        st <= frcu_pkg::W_IDLE;
                    end else begin
                        tmr <= tmr - 24'h1;
                    end
                end
                default: st <= frcu_pkg::W_IDLE;
            endcase
        end
    end

    // Enable stays set when a write is discarded for a wrong length
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wel <= 1'b0;
        end else if (done || lk_ok || vcr_ok || evcr_ok) begin
            wel <= 1'b0;
        end else if (wren) begin
            wel <= 1'b1;
        end else if (wrdi) begin
            wel <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stat_hi <= frcu_pkg::STAT_RST;
        end else if (sr_ok) begin
            stat_hi <= cap.shf[7:2];
        end
    end

    // First data byte received is the low byte
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            nvcr    <= frcu_pkg::NVCR_RST;
            nv_pend <= frcu_pkg::NVCR_RST;
        end else if (nv_ok) begin
            nv_pend <= {cap.shf[7:0], cap.shf[15:8]};
        end else if (done && st == frcu_pkg::W_NVCR) begin
            nvcr <= nv_pend;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            vcr  <= frcu_pkg::VCR_RST;
            evcr <= frcu_pkg::EVCR_RST;
        end else if (vcr_ok) begin
            vcr <= (vcr & frcu_pkg::VCR_RSVD) | (cap.shf[7:0] & ~frcu_pkg::VCR_RSVD);
        end else if (evcr_ok) begin
            evcr <= (evcr & frcu_pkg::EVCR_RSVD) | (cap.shf[7:0] & ~frcu_pkg::EVCR_RSVD);
        end
    end

    // A new error wins over a clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            err <= 3'h0;
        end else begin
            err <= (err & ~{3{clr}}) | i_err_set;
        end
    end

    for (genvar s = 0; s < N_SECT; s++) begin : g_lock
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                lkw[s] <= 1'b0;
                lkd[s] <= 1'b0;
            end else if (lk_ok && wsec == SB'(s) && !lkd[s]) begin
                lkd[s] <= cap.shf[1];
                lkw[s] <= cap.shf[0];
            end
        end
        property p_lock_hold;
            @(posedge i_clk) disable iff (i_rst) lkd[s] |=> lkd[s] && $stable(lkw[s]);
        endproperty
        a_lock_hold: assert property (p_lock_hold) else $error("lock bits moved");
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pe_block <= 1'b0;
        end else begin
            o_pe_block <= lkw[i_pe_sector];
        end
    end

    always_comb begin
        view                            = '0;
        view.status                     = {stat_hi, wel, wip};
        view.flags[frcu_pkg::FSR_READY] = ~lock_busy;
        view.flags[frcu_pkg::FSR_ERASE] = err[2];
        view.flags[frcu_pkg::FSR_PROG]  = err[1];
        view.flags[frcu_pkg::FSR_PROT]  = err[0];
        view.vcr                        = vcr;
        view.evcr                       = evcr;
        view.nvcr                       = nvcr | frcu_pkg::NVCR_RSVD;
        view.busy                       = lock_busy;
        view.proto                      = i_proto;
    end

    always_ff @(posedge i_clk) begin
        view_q <= view;
    end

    assign o_status = {stat_hi, wel, wip};
    assign o_flags  = view_q.flags;
    assign o_nvcr   = nvcr;
    assign o_vcr    = vcr;
    assign o_evcr   = evcr;

    // ****************************************
    // Checks
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_rst || !wip) begin
            busy_len <= 24'h0;
        end else begin
            busy_len <= busy_len + 24'h1;
        end
    end

    sequence s_stat_end;
        (st == frcu_pkg::W_STAT) ##1 (st == frcu_pkg::W_IDLE);
    endsequence
    sequence s_nv_end;
        (st == frcu_pkg::W_NVCR) ##1 (st == frcu_pkg::W_IDLE);
    endsequence
    property p_stat_len;
        @(posedge i_clk) disable iff (i_rst)
            s_stat_end |-> $past(busy_len) == 24'(STATUS_WRITE_CYC - 1) && !wel;
    endproperty
    a_stat_len: assert property (p_stat_len) else $error("status write length");
    property p_nv_len;
        @(posedge i_clk) disable iff (i_rst)
            s_nv_end |-> $past(busy_len) == 24'(NV_WRITE_CYC - 1) && o_nvcr == $past(nv_pend);
    endproperty
    a_nv_len: assert property (p_nv_len) else $error("nvcr write length");
    property p_sr_start;
        @(posedge i_clk) disable iff (i_rst)
            sr_ok |=> o_status[0] && o_status[7:2] == $past(cap.shf[7:2]);
    endproperty
    a_sr_start: assert property (p_sr_start) else $error("status write start");
    property p_wip_end;
        @(posedge i_clk) disable iff (i_rst) $fell(o_status[0]) |-> !o_status[1];
    endproperty
    a_wip_end: assert property (p_wip_end) else $error("enable left set");
    property p_no_wel;
        @(posedge i_clk) disable iff (i_rst) (cmd_ok && !wel) |=> $stable(o_status[7:2])
            && $stable(o_vcr) && $stable(o_evcr) && $stable(lkw) && !o_status[0];
    endproperty
    a_no_wel: assert property (p_no_wel) else $error("write without enable");
    property p_bad_len;
        @(posedge i_clk) disable iff (i_rst) (cmd_ok && wel && !wip
            && cap.op == frcu_pkg::OP_WRSR && cap.bits != frcu_pkg::BITS_REG)
            |=> o_status[1] && !o_status[0];
    endproperty
    a_bad_len: assert property (p_bad_len) else $error("bad length accepted");
    property p_lock_down;
        @(posedge i_clk) disable iff (i_rst) (lk_ok && lkd[wsec]) |=> $stable(lkw) && $stable(lkd);
    endproperty
    a_lock_down: assert property (p_lock_down) else $error("locked sector changed");
    property p_lock_wr;
        @(posedge i_clk) disable iff (i_rst) (lk_ok && !lkd[wsec])
            |=> lkw[$past(wsec)] == $past(cap.shf[0]) && !wel;
    endproperty
    a_lock_wr: assert property (p_lock_wr) else $error("lock write lost");
    property p_clear;
        @(posedge i_clk) disable iff (i_rst) clr |=> err == $past(i_err_set);
    endproperty
    a_clear: assert property (p_clear) else $error("flag clear failed");
    property p_vcr_rsvd;
        @(posedge i_clk) disable iff (i_rst) vcr_ok
            |=> (o_vcr & frcu_pkg::VCR_RSVD) == ($past(o_vcr) & frcu_pkg::VCR_RSVD);
    endproperty
    a_vcr_rsvd: assert property (p_vcr_rsvd) else $error("reserved bit written");
    property p_release;
        @(posedge i_clk) disable iff (i_rst) i_cs_n |-> o_dq_oe_n == 4'hf;
    endproperty
    a_release: assert property (p_release) else $error("driving while deselected");
endmodule // frcu_reg_cmd

/* tb/frcu_host.sv */
// Host controller model that frames register commands on the serial link
`timescale 1ns/1ps
module frcu_host (
    // Device side view
    input  wire frcu_pkg::frcu_proto_e i_proto,
    input  wire logic [3:0]            i_dq,
    input  wire logic [3:0]            i_dq_oe_n,
    // Serial link
    output logic                       o_sclk,
    output logic                       o_cs_n,
    output logic      [3:0]            o_dq
);
    logic [3:0] oe_seen;

    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_dq = 4'h5;
        oe_seen = 4'hf;
    end

    // Select rises right after the last bit
    // Two clock pulses while deselected let the link side pick up a new protocol
    // before the first bit; frame state stays cleared while select is high
    // Opcode is followed directly by address or data, no dummy cycles
    task automatic xfer(input logic [63:0] tx, input int ntx, input int nrx,
                        output logic [63:0] rx);
        int         w;
        int         k;
        logic [3:0] msk;
        w = (i_proto == frcu_pkg::PR_QUAD) ? 4 : (i_proto == frcu_pkg::PR_DUAL) ? 2 : 1;
        msk = 4'((1 << w) - 1);
        rx = '0;
        oe_seen = 4'hf;
        repeat (2) begin
            #80 o_sclk = 1'b1;
            #80 o_sclk = 1'b0;
        end
        #37 o_cs_n = 1'b0;
        for (k = 0; k < ntx + nrx; k += w) begin
            // Lanes per protocol, highest lane earliest
            if (k < ntx)
                o_dq = (~o_dq & ~msk) | (4'(tx >> (ntx - k - w)) & msk);
            else
                o_dq = ~o_dq;
            #80;
            if (k >= ntx) begin
                rx = (rx << w) | 64'((i_proto == frcu_pkg::PR_EXT) ?
                                     {3'h0, i_dq[1]} : (i_dq & msk));
                oe_seen = i_dq_oe_n;
            end
            o_sclk = 1'b1;
            #80 o_sclk = 1'b0;
        end
        #40 o_cs_n = 1'b1;
        // Gap long enough for the device to pick up the frame
        #200;
    endtask
endmodule // frcu_host

/* tb/test_flash_register_command_unit.sv */
// Self-checking bench of the flash register command unit
`timescale 1ns/1ps
module test_flash_register_command_unit;
    logic                  clk;
    logic                  rst;
    logic                  busy;
    logic                  susp;
    logic [2:0]            err;
    logic [6:0]            sect;
    frcu_pkg::frcu_proto_e proto;
    logic                  sclk;
    logic                  cs_n;
    logic [3:0]            h_dq;
    logic [3:0]            d_dq;
    logic [3:0]            oe_n;
    logic [3:0]            dq_w;
    logic [7:0]            status;
    logic [7:0]            flags;
    logic [7:0]            vcr;
    logic [7:0]            evcr;
    logic [15:0]           nvcr;
    logic                  blk;
    logic [63:0]           rx;
    int                    mismatches;
    int                    compares;
    int                    i;

    // Device lanes win wherever it drives
    assign dq_w = (d_dq & ~oe_n) | (h_dq & oe_n);

    frcu_reg_cmd #(.N_SECT(128), .STATUS_WRITE_CYC(40), .NV_WRITE_CYC(60)) frcu_reg_cmd_i (
        .i_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_dq(dq_w),
        .o_dq(d_dq), .o_dq_oe_n(oe_n), .i_proto(proto), .i_pe_busy(busy),
        .i_erase_susp(susp), .i_err_set(err), .i_pe_sector(sect), .o_pe_block(blk),
        .o_status(status), .o_flags(flags), .o_nvcr(nvcr), .o_vcr(vcr), .o_evcr(evcr));

    frcu_host frcu_host_i (.i_proto(proto), .i_dq(dq_w), .i_dq_oe_n(oe_n),
                           .o_sclk(sclk), .o_cs_n(cs_n), .o_dq(h_dq));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic report_and_stop;
        if (mismatches == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmd(input logic [63:0] tx, input int ntx, input int nrx);
        frcu_host_i.xfer(tx, ntx, nrx, rx);
        @(negedge clk);
    endtask

    task automatic wait_idle;
        int n;
        for (n = 0; n < 200 && status[0] !== 1'b0; n++) @(negedge clk);
        if (n == 200) begin
            mismatches++;
            report_and_stop();
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        busy = 1'b0;
        susp = 1'b0;
        err = 3'h0;
        sect = 7'h05;
        proto = frcu_pkg::PR_EXT;
        mismatches = 0;
        compares = 0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk("status", 8'h00, status);
        chk("config", 32'hffffffff, {nvcr, vcr, evcr});
        chk("flags", 8'h80, flags);
        chk("block", 1'b0, blk);
        cmd({frcu_pkg::OP_WRSR, 8'hff}, 16, 0);
        chk("status", 8'h00, status);
        cmd(frcu_pkg::OP_WREN, 8, 0);
        cmd(frcu_pkg::OP_WRDI, 8, 0);
        cmd({frcu_pkg::OP_WRSR, 8'hff}, 16, 0);
        chk("status", 8'h00, status);
        cmd(frcu_pkg::OP_WREN, 8, 0);
        cmd({frcu_pkg::OP_WRSR, 8'hff}, 16, 0);
        chk("status", 8'hff, status);
        chk("flags", 8'h00, flags);
        wait_idle();
        chk("status", 8'hfc, status);
        cmd(frcu_pkg::OP_RDSR, 8, 7);
        chk("part read", 8'h7e, rx);
        chk("release", 4'hf, oe_n);
        for (i = 0; i < 3; i++) begin
            proto = frcu_pkg::frcu_proto_e'(i);
            repeat (8) @(negedge clk);
            cmd(frcu_pkg::OP_RDSR, 8, 16);
            chk("status read", 16'hfcfc, rx);
            chk("lanes", (i == 0) ? 4'hd : (i == 1) ? 4'hc : 4'h0, frcu_host_i.oe_seen);
        end
        cmd(frcu_pkg::OP_WREN, 8, 0);
        cmd({frcu_pkg::OP_WRVCR, 16'h0000}, 24, 0);
        chk("status", 8'hfe, status);
        cmd({frcu_pkg::OP_WRSR, 16'h0000}, 24, 0);
        chk("status", 8'hfe, status);
        cmd({frcu_pkg::OP_WRVCR, 8'h00}, 16, 0);
        chk("vcr", 8'h04, vcr);
        cmd(frcu_pkg::OP_RDVCR, 8, 8);
        chk("vcr read", 8'h04, rx);
        cmd(frcu_pkg::OP_WREN, 8, 0);
        cmd({frcu_pkg::OP_WREVCR, 8'h00}, 16, 0);
        chk("evcr", 8'h10, evcr);
        cmd(frcu_pkg::OP_RDEVCR, 8, 16);
        chk("evcr read", 16'h1010, rx);
        cmd(frcu_pkg::OP_WREN, 8, 0);
        cmd({frcu_pkg::OP_WRNVCR, 8'h2c, 8'h12}, 24, 0);
        chk("status", 8'hff, status);
        wait_idle();
        cmd(frcu_pkg::OP_RDNVCR, 8, 32);
        chk("nvcr read", 32'h3c120000, rx);
        cmd(frcu_pkg::OP_WREN, 8, 0);
        cmd({frcu_pkg::OP_WRLOCK, 24'h050000, 8'h01}, 40, 0);
        chk("status", 8'hfc, status);
        chk("block", 1'b1, blk);
        cmd({frcu_pkg::OP_RDLOCK, 24'h050000}, 32, 16);
        chk("lock read", 16'h0101, rx);
        cmd(frcu_pkg::OP_WREN, 8, 0);
        cmd({frcu_pkg::OP_WRLOCK, 24'h050000, 8'h02}, 40, 0);
        cmd(frcu_pkg::OP_WREN, 8, 0);
        cmd({frcu_pkg::OP_WRLOCK, 24'h050000, 8'h01}, 40, 0);
        cmd({frcu_pkg::OP_RDLOCK, 24'h050000}, 32, 8);
        chk("lock read", 8'h02, rx);
        chk("block", 1'b0, blk);
        busy = 1'b1;
        susp = 1'b1;
        sect = 7'h06;
        cmd(frcu_pkg::OP_WREN, 8, 0);
        cmd({frcu_pkg::OP_WRLOCK, 24'h060000, 8'h01}, 40, 0);
        chk("block", 1'b1, blk);
        cmd({frcu_pkg::OP_RDLOCK, 24'h060000}, 32, 8);
        chk("busy lanes", 4'hf, frcu_host_i.oe_seen);
        busy = 1'b0;
        susp = 1'b0;
        @(negedge clk) err = 3'h7;
        @(negedge clk) err = 3'h0;
        repeat (3) @(negedge clk);
        chk("flags", 8'hb2, flags);
        cmd(frcu_pkg::OP_RDFSR, 8, 8);
        chk("flag read", 8'hb2, rx);
        cmd(frcu_pkg::OP_CLFSR, 8, 0);
        chk("flags", 8'h80, flags);
        report_and_stop();
    end
endmodule // test_flash_register_command_unit
